//--- sync_serial_consts.vh
/*
 * constants for the clock-synchronous serial unit: register offsets,
 * field positions, reset values and timing counts.
 * assumes a 100 MHz bus clock and 32-bit AXI4-Lite register access.
 */
// Functional notes
// - clock source 0 makes device master, 1 makes it external-clock slave
// - two divider source bits pick count source; 8-bit divider sets rate
// - handshake disable must be 1; handshake select then ignored
// - tx pin drive type bit selects push-pull or open-drain output
// - clock polarity and phase together give four sampling arrangements
// - transfers start only while transmit enable is 1
// - received data accepted only while receive enable is 1
// - readable flag shows transmit buffer empty
// - readable flag shows transmit shift register empty
// - readable flag shows a received byte is complete
// - tx interrupt source bit picks buffer empty or transmit complete
`ifndef SYNC_SERIAL_CONSTS_VH
`define SYNC_SERIAL_CONSTS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_MODE 8'h00
`define OFS_CTRL0 8'h04
`define OFS_CTRL1 8'h08
`define OFS_BAUD 8'h0C
`define OFS_TXDATA 8'h10
`define OFS_RXDATA 8'h14
`define OFS_SMA 8'h18
`define OFS_SMB 8'h1C
`define OFS_SMC 8'h20
`define OFS_SMD 8'h24

// ****************************************************************
// field positions
// ****************************************************************
`define MODE_SEL_LO 0
`define MODE_CLKSRC 3
`define MODE_INVERT 6
`define C0_DIVSRC_LO 0
`define C0_HSFUNC 2
`define C0_TXSHE 3
`define C0_HSDIS 4
`define C0_DRIVE 5
`define C0_POL 6
`define C0_ORDER 7
`define C1_TXEN 0
`define C1_TBE 1
`define C1_RXEN 2
`define C1_RXDONE 3
`define C1_IRQSRC 4
`define SMC_PHASE 1

// ****************************************************************
// values
// ****************************************************************
`define MODE_SYNC 3'b001
`define RST_MODE 8'h00
`define RST_CTRL0 8'h18
`define RST_CTRL1 8'h02
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define BITS_PER_FRAME 4'h8

`endif

//--- sync_serial.v
/*
 * clock-synchronous serial unit with AXI4-Lite register access.
 * assumes the peer drives the serial clock in slave mode; all input pins
 * come from outside and are synchronised on clk.
 */
`include "sync_serial_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module sync_serial #(
  parameter DIV_W = 8
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // axi4-lite write
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // serial pins
  input wire [3:0] count_src_tick,
  input wire serial_clk_in,
  output reg serial_clk_out,
  output reg serial_clk_oe_n,
  input wire serial_rx_pin,
  output reg serial_tx_pin,
  output reg serial_tx_oe_n,
  // transmit interrupt request level
  output reg tx_irq_req
);

  // ****************************************************************
  // registers
  // ****************************************************************
  reg [7:0] serial_mode_reg_r;
  reg [7:0] control0_reg_r;
  reg [7:0] control1_reg_r;
  reg [DIV_W-1:0] baud_divider_r;
  reg [7:0] tx_buf_r;
  reg [7:0] rx_buf_r;
  reg [7:0] special_mode_reg_a_r;
  reg [7:0] special_mode_reg_b_r;
  reg [7:0] special_mode_reg_c_r;
  reg [7:0] special_mode_reg_d_r;
  reg tx_buf_empty_flag_r;
  reg tx_shift_empty_r;
  reg rx_done_flag_r;

  wire [2:0] serial_mode_sel = serial_mode_reg_r[`MODE_SEL_LO+2:`MODE_SEL_LO];
  wire clk_source_sel = serial_mode_reg_r[`MODE_CLKSRC];
  wire line_invert = serial_mode_reg_r[`MODE_INVERT];
  wire [1:0] divider_source_sel =
    control0_reg_r[`C0_DIVSRC_LO+1:`C0_DIVSRC_LO];
  wire handshake_disable = control0_reg_r[`C0_HSDIS];
  wire tx_pin_drive_type = control0_reg_r[`C0_DRIVE];
  wire clk_polarity = control0_reg_r[`C0_POL];
  wire bit_order_sel = control0_reg_r[`C0_ORDER];
  wire tx_enable = control1_reg_r[`C1_TXEN];
  wire rx_enable = control1_reg_r[`C1_RXEN];
  wire tx_irq_source = control1_reg_r[`C1_IRQSRC];
  wire clk_phase_sel = special_mode_reg_c_r[`SMC_PHASE];
  wire mode_on = (serial_mode_sel == `MODE_SYNC);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  reg [1:0] sclk_sync_r;
  reg [1:0] rx_sync_r;
  reg [1:0] tick_meta_r [0:3];
  reg [3:0] tick_sync_r;
  reg [3:0] tick_prev_r;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_tick
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          tick_meta_r[gi] <= 2'b00;
          tick_prev_r[gi] <= 1'b0;
        end else begin
          tick_meta_r[gi] <= {tick_meta_r[gi][0], count_src_tick[gi]};
          tick_prev_r[gi] <= tick_meta_r[gi][1];
        end
      end
      always @* tick_sync_r[gi] = tick_meta_r[gi][1] & ~tick_prev_r[gi];
    end
  endgenerate
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sync_r <= 2'b00;
      rx_sync_r <= 2'b00;
    end else begin
      sclk_sync_r <= {sclk_sync_r[0], serial_clk_in};
      rx_sync_r <= {rx_sync_r[0], serial_rx_pin};
    end
  end

  // ****************************************************************
  // baud generator
  // ****************************************************************
  reg [DIV_W-1:0] div_cnt_r;
  reg int_clk_r;
  reg ext_prev_r;
  wire src_tick = tick_sync_r[divider_source_sel];
  wire div_wrap = src_tick && (div_cnt_r == {DIV_W{1'b0}});
  reg busy_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_r <= {DIV_W{1'b0}};
      int_clk_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= sclk_sync_r[1];
      if (!busy_r) begin
        div_cnt_r <= baud_divider_r;
        int_clk_r <= 1'b0;
      end else if (src_tick) begin
        if (div_wrap) begin
          div_cnt_r <= baud_divider_r;
          int_clk_r <= ~int_clk_r;
        end else begin
          div_cnt_r <= div_cnt_r - 1'b1;
        end
      end
    end
  end
  // master edges from divider, slave edges from peer clock
  wire int_rise = div_wrap && !int_clk_r && busy_r;
  wire int_fall = div_wrap && int_clk_r && busy_r;
  wire ext_rise = sclk_sync_r[1] && !ext_prev_r;
  wire ext_fall = !sclk_sync_r[1] && ext_prev_r;
  wire lead = clk_source_sel ? (ext_rise ^ (ext_rise|ext_fall) & clk_polarity)
                             : (int_rise ^ (int_rise|int_fall) & clk_polarity);
  wire any_edge = clk_source_sel ? (ext_rise | ext_fall)
                                 : (int_rise | int_fall);
  wire lead_edge = any_edge & lead;
  wire trail_edge = any_edge & ~lead;
  // phase 0 samples on leading edge, phase 1 on trailing
  wire sample_edge = clk_phase_sel ? trail_edge : lead_edge;
  wire shift_edge = clk_phase_sel ? lead_edge : trail_edge;

  // ****************************************************************
  // shifter
  // ****************************************************************
  reg [7:0] tx_sh_r;
  reg [7:0] rx_sh_r;
  reg [3:0] bit_cnt_r;
  reg first_r;
  wire start = mode_on && tx_enable && !busy_r && !tx_buf_empty_flag_r;
  wire rx_bit = rx_sync_r[1] ^ line_invert;
  wire frame_end = busy_r && sample_edge && (bit_cnt_r == `BITS_PER_FRAME - 1);
  wire tx_bit = (bit_order_sel ? tx_sh_r[7] : tx_sh_r[0]) ^ line_invert;
  wire tx_pin_nxt = (busy_r && (first_r || shift_edge)) ? tx_bit
                                                        : serial_tx_pin;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_r <= 8'h00;
      rx_sh_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      busy_r <= 1'b0;
      first_r <= 1'b0;
      serial_tx_pin <= 1'b1;
    end else begin
      if (start) begin
        tx_sh_r <= tx_buf_r;
        busy_r <= 1'b1;
        bit_cnt_r <= 4'h0;
        first_r <= ~clk_phase_sel;
      end else if (busy_r) begin
        if (first_r) begin
          serial_tx_pin <= tx_bit;
          first_r <= 1'b0;
        end else if (shift_edge) begin
          serial_tx_pin <= tx_bit;
        end
        if (sample_edge) begin
          rx_sh_r <= bit_order_sel ? {rx_sh_r[6:0], rx_bit}
                                   : {rx_bit, rx_sh_r[7:1]};
          tx_sh_r <= bit_order_sel ? {tx_sh_r[6:0], 1'b0}
                                   : {1'b0, tx_sh_r[7:1]};
          bit_cnt_r <= bit_cnt_r + 1'b1;
          if (frame_end) busy_r <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // pin drivers
  // ****************************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_clk_out <= 1'b0;
      serial_clk_oe_n <= 1'b1;
      serial_tx_oe_n <= 1'b1;
    end else begin
      serial_clk_out <= int_clk_r ^ clk_polarity;
      serial_clk_oe_n <= ~(mode_on & ~clk_source_sel);
      // open-drain releases the pin on a one
      serial_tx_oe_n <= ~mode_on | (tx_pin_drive_type & tx_pin_nxt);
    end
  end

  // ****************************************************************
  // bus slave
  // ****************************************************************
  reg [7:0] aw_r;
  reg [31:0] w_r;
  reg [3:0] ws_r;
  reg aw_ok_r;
  reg w_ok_r;
  wire do_wr = aw_ok_r && w_ok_r && !s_axi_bvalid;
  wire wr_tx = do_wr && aw_r == `OFS_TXDATA && ws_r[0];
  wire wr_c1 = do_wr && aw_r == `OFS_CTRL1 && ws_r[0];
  wire rd_rx = s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFS_RXDATA;
  reg hit;
  always @* begin
    case (aw_r)
      `OFS_MODE, `OFS_CTRL0, `OFS_CTRL1, `OFS_BAUD, `OFS_TXDATA,
      `OFS_SMA, `OFS_SMB, `OFS_SMC, `OFS_SMD: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      aw_r <= 8'h00;
      w_r <= 32'h0000_0000;
      ws_r <= 4'h0;
      serial_mode_reg_r <= `RST_MODE;
      control0_reg_r <= `RST_CTRL0;
      control1_reg_r <= 8'h00;
      baud_divider_r <= {DIV_W{1'b0}};
      tx_buf_r <= 8'h00;
      special_mode_reg_a_r <= 8'h00;
      special_mode_reg_b_r <= 8'h00;
      special_mode_reg_c_r <= 8'h00;
      special_mode_reg_d_r <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_r <= s_axi_awaddr;
        aw_ok_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_r <= s_axi_wdata;
        ws_r <= s_axi_wstrb;
        w_ok_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= hit ? `RESP_OKAY : `RESP_SLVERR;
        if (ws_r[0]) begin
          case (aw_r)
            `OFS_MODE: serial_mode_reg_r <= w_r[7:0];
            // tx shift empty is read only; handshake disable forced
            `OFS_CTRL0: control0_reg_r <= {w_r[7:5], 1'b1, 1'b0, w_r[2:0]};
            `OFS_CTRL1: control1_reg_r <= w_r[7:0];
            `OFS_BAUD: baud_divider_r <= w_r[DIV_W-1:0];
            `OFS_TXDATA: tx_buf_r <= w_r[7:0];
            `OFS_SMA: special_mode_reg_a_r <= w_r[7:0];
            `OFS_SMB: special_mode_reg_b_r <= w_r[7:0];
            `OFS_SMC: special_mode_reg_c_r <= w_r[7:0];
            `OFS_SMD: special_mode_reg_d_r <= w_r[7:0];
            default: ;
          endcase
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // status flags; rx done hardware set wins over software clear, but a tx data write wins over the buffer-empty set on start
  // ****************************************************************
  wire rx_take = frame_end && rx_enable && mode_on;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_buf_empty_flag_r <= 1'b1;
      tx_shift_empty_r <= 1'b1;
      rx_done_flag_r <= 1'b0;
      rx_buf_r <= 8'h00;
      tx_irq_req <= 1'b0;
    end else begin
      if (wr_tx) tx_buf_empty_flag_r <= 1'b0;
      else if (start) tx_buf_empty_flag_r <= 1'b1;
      tx_shift_empty_r <= ~busy_r & ~start;
      if (rx_take) begin
        rx_done_flag_r <= 1'b1;
        rx_buf_r <= bit_order_sel ? {rx_sh_r[6:0], rx_bit}
                                  : {rx_bit, rx_sh_r[7:1]};
      end else if (rd_rx || (wr_c1 && !w_r[`C1_RXDONE])) begin
        rx_done_flag_r <= 1'b0;
      end
      tx_irq_req <= mode_on && tx_enable && (tx_irq_source ?
        (tx_shift_empty_r & tx_buf_empty_flag_r) : tx_buf_empty_flag_r);
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  reg [7:0] rd_val;
  reg rd_hit;
  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `OFS_MODE: rd_val = serial_mode_reg_r;
      `OFS_CTRL0: rd_val = {control0_reg_r[7:4], tx_shift_empty_r,
                            control0_reg_r[2:0]};
      `OFS_CTRL1: rd_val = {control1_reg_r[7:4], rx_done_flag_r,
                            control1_reg_r[2], tx_buf_empty_flag_r,
                            control1_reg_r[0]};
      `OFS_BAUD: rd_val = baud_divider_r;
      `OFS_TXDATA: rd_val = tx_buf_r;
      `OFS_RXDATA: rd_val = rx_buf_r;
      `OFS_SMA: rd_val = special_mode_reg_a_r;
      `OFS_SMB: rd_val = special_mode_reg_b_r;
      `OFS_SMC: rd_val = special_mode_reg_c_r;
      `OFS_SMD: rd_val = special_mode_reg_d_r;
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_val};
        s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

//--- sync_serial_peer.sv
/*
 * spi-style peer that clocks the serial unit in slave mode.
 * assumes the bench raises go after the design holds its tx byte,
 * and lowers go again once done is seen.
 */
`timescale 1ns/1ps
`default_nettype none
module sync_serial_peer (
  // bench side
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] tx_byte,
  output logic [7:0] got,
  output logic done,
  // serial side
  input wire logic tx_line,
  output logic serial_clk_in,
  output logic serial_rx_pin
);
  integer i;
  initial begin
    serial_clk_in = 1'b0;
    serial_rx_pin = 1'b1;
    got = 8'h00;
    done = 1'b0;
  end
  // ****************************************************************
  // one frame, msb first, clock stands low outside frames
  // ****************************************************************
  always @(posedge go) begin
    done <= 1'b0;
    for (i = 7; i >= 0; i = i - 1) begin
      serial_rx_pin <= tx_byte[i];
      repeat (8) @(posedge clk);
      serial_clk_in <= 1'b1;
      repeat (8) @(posedge clk);
      got[i] = tx_line;
      repeat (8) @(posedge clk);
      serial_clk_in <= 1'b0;
      repeat (8) @(posedge clk);
    end
    serial_rx_pin <= ~tx_byte[0];
    done <= 1'b1;
  end
endmodule
`default_nettype wire

//--- sync_serial_monitor.sv
/*
 * checker for bus timing and pin drive of the serial unit.
 * assumes it is bound to sync_serial and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module sync_serial_monitor (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // serial pins
  input wire serial_clk_out,
  input wire serial_clk_oe_n,
  input wire serial_tx_pin,
  input wire serial_tx_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  reg [7:0] ar_r;
  wire ar_ok = (ar_r <= 8'h24) && (ar_r[1:0] == 2'b00);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      ar_r <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready)
      ar_r <= s_axi_araddr;
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[2:3] s_axi_bvalid;
  endproperty
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_b_end;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_r_end;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_r_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_rd_data;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000 &&
      s_axi_rresp == (ar_ok ? 2'b00 : 2'b10) &&
      (ar_ok || s_axi_rdata == 32'h0000_0000);
  endproperty
  property p_tx_drv;
    !serial_tx_pin |-> !serial_tx_oe_n;
  endproperty
  property p_clk_drv;
    $changed(serial_clk_out) |-> !serial_clk_oe_n;
  endproperty
  a_wr_lat: assert property (p_wr_lat)
    else $error("write response late");
  a_rd_lat: assert property (p_rd_lat)
    else $error("read response late");
  a_b_end: assert property (p_b_end)
    else $error("write response not released");
  a_r_end: assert property (p_r_end)
    else $error("read response not released");
  a_w_block: assert property (p_w_block)
    else $error("write taken while response pending");
  a_r_block: assert property (p_r_block)
    else $error("read taken while response pending");
  a_rd_data: assert property (p_rd_data)
    else $error("bad read data or response");
  a_tx_drv: assert property (p_tx_drv)
    else $error("tx low without drive");
  a_clk_drv: assert property (p_clk_drv)
    else $error("clock moves without drive");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd_err: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  c_clk_run: cover property ($changed(serial_clk_out));
endmodule
bind sync_serial sync_serial_monitor i_sync_serial_monitor (
  .clk(clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .serial_clk_out(serial_clk_out), .serial_clk_oe_n(serial_clk_oe_n),
  .serial_tx_pin(serial_tx_pin), .serial_tx_oe_n(serial_tx_oe_n));
`default_nettype wire

//--- tb_top.sv
/*
 * self-checking bench for sync_serial over the register bus.
 * assumes the peer model and the bound checker are compiled first.
 */
`include "sync_serial_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [7:0] e;
    logic [1:0] br;
    logic [1:0] rr;
  } row_t;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b1;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b1;
  logic [3:0] count_src_tick = 4'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire serial_clk_in, serial_clk_out, serial_clk_oe_n;
  wire serial_rx_pin, serial_tx_pin, serial_tx_oe_n, tx_irq_req;
  wire tx_line = serial_tx_oe_n ? 1'b1 : serial_tx_pin;
  wire [7:0] got;
  wire done;
  logic go = 1'b0;
  logic [7:0] pbyte = 8'h00;
  logic prev = 1'b0;
  logic [31:0] d32;
  logic [1:0] r2;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int ntog = 0;
  int n0 = 0;
  row_t rows [10];

  sync_serial i_sync_serial (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .count_src_tick(count_src_tick),
    .serial_clk_in(serial_clk_in), .serial_clk_out(serial_clk_out),
    .serial_clk_oe_n(serial_clk_oe_n), .serial_rx_pin(serial_rx_pin),
    .serial_tx_pin(serial_tx_pin), .serial_tx_oe_n(serial_tx_oe_n),
    .tx_irq_req(tx_irq_req));
  sync_serial_peer i_sync_serial_peer (
    .clk(clk), .go(go), .tx_byte(pbyte), .got(got), .done(done),
    .tx_line(tx_line), .serial_clk_in(serial_clk_in),
    .serial_rx_pin(serial_rx_pin));

  always #5 clk = ~clk;
  // only count input 2 ticks; clock toggles counted; hang cut short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    count_src_tick <= {1'b0, cyc[1], 2'b00};
    prev <= serial_clk_out;
    if (prev !== serial_clk_out)
      ntog <= ntog + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      close_out;
    end
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d,
          output logic [1:0] r);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        dd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d,
          output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task frame(input logic [7:0] b);
    pbyte <= b;
    go <= 1'b1;
    do @(posedge clk); while (done !== 1'b1);
    go <= 1'b0;
  endtask
  task close_out;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    rows = '{
      '{1'b0, `OFS_MODE, 32'h0, 8'h00, 2'b00, 2'b00},
      '{1'b0, `OFS_CTRL0, 32'h0, 8'h18, 2'b00, 2'b00},
      '{1'b0, `OFS_CTRL1, 32'h0, 8'h02, 2'b00, 2'b00},
      '{1'b1, `OFS_CTRL0, 32'h0000_0080, 8'h98, 2'b00, 2'b00},
      '{1'b1, `OFS_BAUD, 32'hFFFF_FF01, 8'h01, 2'b00, 2'b00},
      '{1'b1, `OFS_SMA, 32'h0, 8'h00, 2'b00, 2'b00},
      '{1'b1, `OFS_SMD, 32'h0, 8'h00, 2'b00, 2'b00},
      '{1'b1, `OFS_RXDATA, 32'h0000_0055, 8'h00, 2'b10, 2'b00},
      '{1'b1, 8'h28, 32'h0000_0001, 8'h00, 2'b10, 2'b10},
      '{1'b1, `OFS_MODE, 32'h0000_0001, 8'h01, 2'b00, 2'b00}};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[k]) begin
      if (rows[k].w) begin
        wr(rows[k].a, rows[k].d, r2);
        chk(r2, rows[k].br);
      end
      rd(rows[k].a, d32, r2);
      chk(d32, rows[k].e);
      chk(r2, rows[k].rr);
    end
    // master frame, irq on transmit complete
    wr(`OFS_CTRL0, 32'h0000_0082, r2);
    wr(`OFS_CTRL1, 32'h0000_0011, r2);
    n0 = ntog;
    wr(`OFS_TXDATA, 32'h0000_00C3, r2);
    repeat (20) @(posedge clk);
    chk(tx_irq_req, 1'b0);
    chk(serial_clk_oe_n, 1'b0);
    chk(serial_tx_oe_n, 1'b0);
    rd(`OFS_CTRL0, d32, r2);
    chk(d32[3], 1'b0);
    do rd(`OFS_CTRL0, d32, r2); while (d32[3] !== 1'b1);
    repeat (2) @(posedge clk);
    chk(ntog - n0, 16);
    chk(tx_irq_req, 1'b1);
    // slave frames, open-drain tx, msb first
    wr(`OFS_MODE, 32'h0000_0009, r2);
    wr(`OFS_CTRL0, 32'h0000_00A0, r2);
    wr(`OFS_CTRL1, 32'h0000_0005, r2);
    wr(`OFS_TXDATA, 32'h0000_00A5, r2);
    frame(8'h3C);
    chk(got, 8'hA5);
    chk(tx_irq_req, 1'b1);
    chk(serial_tx_oe_n, 1'b1);
    rd(`OFS_CTRL1, d32, r2);
    chk(d32[3:1], 3'b111);
    rd(`OFS_RXDATA, d32, r2);
    chk(d32, 32'h0000_003C);
    wr(`OFS_CTRL1, 32'h0000_0001, r2);
    wr(`OFS_TXDATA, 32'h0000_005A, r2);
    frame(8'h81);
    chk(got, 8'h5A);
    rd(`OFS_CTRL1, d32, r2);
    chk(d32[3], 1'b0);
    // reset in mid-run
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid,
      s_axi_rvalid, serial_tx_pin, serial_tx_oe_n, serial_clk_out,
      tx_irq_req}, 9'h1CC);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`OFS_CTRL0, d32, r2);
    chk(d32, 32'h0000_0018);
    close_out;
  end
endmodule
`default_nettype wire
